// ### core/alu_flag_calc.sv
// Combinational result and flag calculation for one operation
module alu_flag_calc
(
   alu_flag_if.calc fi
);
   import core_regs_pkg::*;

   // Sum, nibble and carry terms for every operation
   always_comb
   begin
      logic [7:0] bb;
      logic [4:0] cin_w;
      logic [4:0] lo;
      logic [7:0] hi7;
      logic [8:0] full;
      logic       cin;
      bb       = fi.b;
      cin      = 1'b0;
      fi.result = 8'h00;
      fi.flags  = 4'h0;
      fi.affect = 4'h0;
      unique case (fi.op)
         OP_SUB, OP_SBC: bb = ~fi.b;
         default:        bb = fi.b;
      endcase
      unique case (fi.op)
         OP_ADC, OP_SBC: cin = fi.carry_in;
         OP_SUB:         cin = 1'b1;
         default:        cin = 1'b0;
      endcase
      cin_w = {4'h0, cin};
      lo    = {1'b0, fi.a[3:0]} + {1'b0, bb[3:0]} + cin_w;
      hi7   = {1'b0, fi.a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
      full  = {1'b0, fi.a} + {1'b0, bb} + {8'h00, cin};
      unique case (fi.op)
         OP_ADD, OP_ADC, OP_SUB, OP_SBC:
         begin
            fi.result         = full[7:0];
            fi.flags[BIT_C]   = full[8];
            fi.flags[BIT_AC]  = lo[4];
            fi.flags[BIT_OV]  = hi7[7] ^ full[8];
            fi.affect         = 4'hf;
         end
         OP_AND, OP_OR, OP_XOR, OP_INC, OP_DEC:
         begin
            unique case (fi.op)
               OP_AND:  fi.result = fi.a & fi.b;
               OP_OR:   fi.result = fi.a | fi.b;
               OP_XOR:  fi.result = fi.a ^ fi.b;
               OP_INC:  fi.result = fi.a + 8'h01;
               default: fi.result = fi.a - 8'h01;
            endcase
            fi.affect[BIT_Z] = 1'b1;
         end
         OP_RLC:
         begin
            fi.result        = {fi.a[6:0], fi.carry_in};
            fi.flags[BIT_C]  = fi.a[7];
            fi.affect[BIT_C] = 1'b1;
         end
         OP_RRC:
         begin
            fi.result        = {fi.carry_in, fi.a[7:1]};
            fi.flags[BIT_C]  = fi.a[0];
            fi.affect[BIT_C] = 1'b1;
         end
         default:
         begin
            fi.result = 8'h00;
            fi.affect = 4'h0;
         end
      endcase
      fi.flags[BIT_Z] = (fi.result == 8'h00);
   end

endmodule

// ### core/alu_flag_if.sv
// Interface between the register block and the flag calculator
interface alu_flag_if;
   import core_regs_pkg::*;

   alu_op_t   op;
   logic [7:0] a;
   logic [7:0] b;
   logic       carry_in;
   logic [7:0] result;
   flag_vec_t  flags;
   flag_vec_t  affect;

   modport calc
   (
      input  op,
      input  a,
      input  b,
      input  carry_in,
      output result,
      output flags,
      output affect
   );

   modport core
   (
      output op,
      output a,
      output b,
      output carry_in,
      input  result,
      input  flags,
      input  affect
   );

endinterface

// ### core/core_regs_pkg.sv
// Constants and types for the core status and program registers
package core_regs_pkg;

   // ------------------------------------------------------------
   // Register offsets on the special function port
   // ------------------------------------------------------------
   localparam logic [2:0] OFS_STATUS = 3'h0;
   localparam logic [2:0] OFS_PCL    = 3'h1;
   localparam logic [2:0] OFS_TABLE_POINTER_LOW   = 3'h2;
   localparam logic [2:0] OFS_TABLE_POINTER_HIGH   = 3'h3;
   localparam logic [2:0] OFS_TABLE_RESULT_HIGH   = 3'h4;

   // ------------------------------------------------------------
   // Status field positions
   // ------------------------------------------------------------
   localparam int BIT_C   = 0;
   localparam int BIT_AC  = 1;
   localparam int BIT_Z   = 2;
   localparam int BIT_OV  = 3;
   localparam int BIT_PDF = 4;
   localparam int BIT_TO  = 5;

   // ------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------
   localparam logic [3:0]  ARITH_RST = 4'h0;
   localparam logic [7:0]  BYTE_RST  = 8'h00;
   localparam logic [15:0] WORD_RST  = 16'h0000;

   // ------------------------------------------------------------
   // Operations of the execution path
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_ADD = 4'h0,
      OP_ADC = 4'h1,
      OP_SUB = 4'h2,
      OP_SBC = 4'h3,
      OP_AND = 4'h4,
      OP_OR  = 4'h5,
      OP_XOR = 4'h6,
      OP_RLC = 4'h7,
      OP_RRC = 4'h8,
      OP_INC = 4'h9,
      OP_DEC = 4'ha
   } alu_op_t;

   // Flags in status order: ov, z, ac, c
   typedef logic [3:0] flag_vec_t;

endpackage

// ### core/core_status_and_program_regs.sv
// Status flags, program counter low byte and table read registers
module core_status_and_program_regs
(
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire logic [2:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output      logic [7:0]             reg_rdata,
   input  wire logic                   alu_valid,
   input  wire core_regs_pkg::alu_op_t alu_op,
   input  wire logic [7:0]             alu_a,
   input  wire logic [7:0]             alu_b,
   output      logic [7:0]             alu_result,
   output      logic                   alu_done,
   input  wire logic                   wdt_timeout,
   input  wire logic                   wdt_clear_instr,
   input  wire logic                   sleep_instr,
   input  wire logic [7:0]             pc_now_low,
   output      logic                   pc_load,
   output      logic [7:0]             pc_target_low,
   output      logic                   pc_bubble,
   input  wire logic                   tbl_read_instr,
   output      logic                   tbl_fetch,
   output      logic [15:0]            tbl_fetch_addr,
   input  wire logic                   prog_word_valid,
   input  wire logic [15:0]            prog_word,
   output      logic                   tbl_low_valid,
   output      logic [7:0]             tbl_low_data
);
   import core_regs_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [3:0]  arith_q;
   logic        to_q;
   logic        pdf_q;
   logic [7:0]  table_pointer_low_q;
   logic [7:0]  table_pointer_high_q;
   logic [7:0]  table_result_high_q;
   logic [7:0]  rdata_q;
   logic [7:0]  result_q;
   logic        done_q;
   logic        pc_load_q;
   logic [7:0]  pc_target_q;
   logic        bubble_q;
   logic        fetch_q;
   logic [15:0] fetch_addr_q;
   logic        low_valid_q;
   logic [7:0]  low_data_q;
   logic        wr_status;
   logic [7:0]  status_view;

   alu_flag_if fi ();

   // ------------------------------------------------------------
   // Flag calculator
   // ------------------------------------------------------------
   assign fi.op       = alu_op;
   assign fi.a        = alu_a;
   assign fi.b        = alu_b;
   assign fi.carry_in = arith_q[BIT_C];

   alu_flag_calc u_calc
   (
      .fi (fi.calc)
   );

   // Decoded status write and read view
   assign wr_status   = reg_wr && (reg_addr == OFS_STATUS);
   assign status_view = {2'b00, to_q, pdf_q, arith_q};

   // ------------------------------------------------------------
   // Arithmetic flags
   // ------------------------------------------------------------
   // Operation wins over a software write in the same cycle on the flags it affects; the write sets the others
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         arith_q <= ARITH_RST;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (alu_valid && fi.affect[i])
            begin
               arith_q[i] <= fi.flags[i];
            end
            else if (wr_status)
            begin
               arith_q[i] <= reg_wdata[i];
            end
         end
      end
   end

   // Operation result towards the accumulator
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         result_q <= BYTE_RST;
         done_q   <= 1'b0;
      end
      else
      begin
         done_q <= alu_valid;
         if (alu_valid)
         begin
            result_q <= fi.result;
         end
      end
   end

   // ------------------------------------------------------------
   // System flags
   // ------------------------------------------------------------
   // Expiry flag, timeout wins over a clear
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         to_q <= 1'b0;
      end
      else if (wdt_timeout)
      begin
         to_q <= 1'b1;
      end
      else if (wdt_clear_instr || sleep_instr)
      begin
         to_q <= 1'b0;
      end
   end

   // Sleep flag, ignores status writes
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pdf_q <= 1'b0;
      end
      else if (sleep_instr)
      begin
         pdf_q <= 1'b1;
      end
      else if (wdt_clear_instr)
      begin
         pdf_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Program counter low byte
   // ------------------------------------------------------------
   // Write loads the low byte and stalls one cycle
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pc_load_q   <= 1'b0;
         bubble_q    <= 1'b0;
         pc_target_q <= BYTE_RST;
      end
      else
      begin
         pc_load_q <= reg_wr && (reg_addr == OFS_PCL);
         bubble_q  <= reg_wr && (reg_addr == OFS_PCL);
         if (reg_wr && (reg_addr == OFS_PCL))
         begin
            pc_target_q <= reg_wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Table pointers and table read
   // ------------------------------------------------------------
   // Pointers, read-modify-write from inc or dec works
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         table_pointer_low_q <= BYTE_RST;
         table_pointer_high_q <= BYTE_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == OFS_TABLE_POINTER_LOW)
         begin
            table_pointer_low_q <= reg_wdata;
         end
         if (reg_addr == OFS_TABLE_POINTER_HIGH)
         begin
            table_pointer_high_q <= reg_wdata;
         end
      end
   end

   // Fetch request towards program memory
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         fetch_q      <= 1'b0;
         fetch_addr_q <= WORD_RST;
      end
      else
      begin
         fetch_q <= tbl_read_instr;
         if (tbl_read_instr)
         begin
            fetch_addr_q <= {table_pointer_high_q, table_pointer_low_q};
         end
      end
   end

   // Returned word: high byte kept, low byte passed on
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         table_result_high_q      <= BYTE_RST;
         low_valid_q <= 1'b0;
         low_data_q  <= BYTE_RST;
      end
      else
      begin
         low_valid_q <= prog_word_valid;
         if (prog_word_valid)
         begin
            table_result_high_q     <= prog_word[15:8];
            low_data_q <= prog_word[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   // Data valid only the cycle after the strobe, else zero
   // No automatic save exists; status changes only as above
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rdata_q <= BYTE_RST;
      end
      else if (reg_rd)
      begin
         unique case (reg_addr)
            OFS_STATUS: rdata_q <= status_view;
            OFS_PCL:    rdata_q <= pc_now_low;
            OFS_TABLE_POINTER_LOW:   rdata_q <= table_pointer_low_q;
            OFS_TABLE_POINTER_HIGH:   rdata_q <= table_pointer_high_q;
            OFS_TABLE_RESULT_HIGH:   rdata_q <= table_result_high_q;
            default:    rdata_q <= BYTE_RST;
         endcase
      end
      else
      begin
         rdata_q <= BYTE_RST;
      end
   end

   // Outputs
   assign reg_rdata      = rdata_q;
   assign alu_result     = result_q;
   assign alu_done       = done_q;
   assign pc_load        = pc_load_q;
   assign pc_target_low  = pc_target_q;
   assign pc_bubble      = bubble_q;
   assign tbl_fetch      = fetch_q;
   assign tbl_fetch_addr = fetch_addr_q;
   assign tbl_low_valid  = low_valid_q;
   assign tbl_low_data   = low_data_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   chk_sw_keeps_sys: assert property (
      wr_status && !wdt_timeout && !wdt_clear_instr && !sleep_instr
      |=> $stable(to_q) && $stable(pdf_q))
      else $error("status write changed a system flag");

   chk_wdt_sets_to: assert property (
      wdt_timeout |=> to_q)
      else $error("expiry flag not set");

   chk_to_clears: assert property (
      (wdt_clear_instr || sleep_instr) && !wdt_timeout |=> !to_q)
      else $error("expiry flag not cleared");

   chk_sleep_flag: assert property (
      sleep_instr |=> pdf_q)
      else $error("sleep flag not set or lost");

   chk_pdf_clear: assert property (
      wdt_clear_instr && !sleep_instr |=> !pdf_q)
      else $error("sleep flag not cleared");

   chk_add_carry: assert property (
      alu_valid && alu_op == OP_ADD
      |=> arith_q[BIT_C] == ({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)} > 9'h0ff))
      else $error("add carry wrong");

   chk_sub_borrow: assert property (
      alu_valid && alu_op == OP_SUB
      |=> arith_q[BIT_C] == ($past(alu_a) >= $past(alu_b)))
      else $error("subtract carry wrong");

   chk_rot_carry: assert property (
      alu_valid && alu_op == OP_RLC
      |=> arith_q[BIT_C] == $past(alu_a[7]) && alu_result[0] == $past(arith_q[BIT_C]))
      else $error("rotate through carry wrong");

   chk_nibble_carry: assert property (
      alu_valid && alu_op == OP_ADD
      |=> arith_q[BIT_AC] == ({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])} > 5'h0f))
      else $error("nibble carry wrong");

   chk_zero_flag: assert property (
      alu_valid && alu_op != OP_RLC && alu_op != OP_RRC
      |=> alu_done && arith_q[BIT_Z] == (alu_result == 8'h00))
      else $error("zero flag wrong");

   chk_overflow: assert property (
      alu_valid && alu_op == OP_ADD
      |=> arith_q[BIT_OV] == ($past(alu_a[7]) == $past(alu_b[7])
                              && alu_result[7] != $past(alu_a[7])))
      else $error("overflow flag wrong");

   chk_top_bits_zero: assert property (
      reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[7:6] == 2'b00)
      else $error("unused status bits not zero");

   chk_reset_flags: assert property (disable iff (1'b0)
      sys_rst |=> !to_q && !pdf_q)
      else $error("system flags not cleared by reset");

   chk_pc_jump: assert property (
      reg_wr && reg_addr == OFS_PCL
      |=> pc_load && pc_target_low == $past(reg_wdata))
      else $error("pc low write did not jump");

   chk_dummy_cycle: assert property (
      pc_load |-> pc_bubble)
      else $error("no dummy cycle with jump");

   chk_table_high: assert property (
      prog_word_valid |=> tbl_low_valid && tbl_low_data == $past(prog_word[7:0])
                          && table_result_high_q == $past(prog_word[15:8]))
      else $error("table read bytes wrong");

   chk_flag_hold: assert property (
      alu_valid && (alu_op == OP_AND || alu_op == OP_INC) && !wr_status
      |=> $stable(arith_q[BIT_C]) && $stable(arith_q[BIT_OV]) && $stable(arith_q[BIT_AC]))
      else $error("unaffected flag changed");

   cov_pc_jump:   cover property (reg_wr && reg_addr == OFS_PCL ##1 pc_load);
   cov_wdt_to:    cover property (wdt_timeout ##1 to_q);
   cov_sleep:     cover property (sleep_instr ##1 pdf_q ##[1:20] !pdf_q);
   cov_tbl_read:  cover property (tbl_read_instr ##[1:8] tbl_low_valid);

endmodule

// ### sim/core_status_and_program_regs_tb_top.sv
// Self-checking bench for the core status and program registers
`define CHECK(what, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("[FAIL] %s expected %h seen %h", what, exp, got); \
      end \
   end

module core_status_and_program_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import core_regs_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        sys_clk, sys_rst;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, alu_a, alu_b, alu_result;
   logic        reg_wr, reg_rd, alu_valid, alu_done;
   alu_op_t     alu_op;
   logic        wdt_timeout, wdt_clear_instr, sleep_instr;
   logic [7:0]  pc_now_low, pc_target_low, tbl_low_data;
   logic        pc_load, pc_bubble, tbl_read_instr, tbl_fetch;
   logic [15:0] tbl_fetch_addr, prog_word;
   logic        prog_word_valid, tbl_low_valid;
   int          miscompares, compares;
   logic [1:0]  exp_sys;  // Expiry and sleep flags
   logic [3:0]  exp_ar;   // Overflow, zero, nibble carry, carry

   core_status_and_program_regs i_core_status_and_program_regs
   (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .alu_valid(alu_valid), .alu_op(alu_op),
      .alu_a(alu_a), .alu_b(alu_b), .alu_result(alu_result),
      .alu_done(alu_done), .wdt_timeout(wdt_timeout),
      .wdt_clear_instr(wdt_clear_instr), .sleep_instr(sleep_instr),
      .pc_now_low(pc_now_low), .pc_load(pc_load),
      .pc_target_low(pc_target_low), .pc_bubble(pc_bubble),
      .tbl_read_instr(tbl_read_instr), .tbl_fetch(tbl_fetch),
      .tbl_fetch_addr(tbl_fetch_addr), .prog_word_valid(prog_word_valid),
      .prog_word(prog_word), .tbl_low_valid(tbl_low_valid),
      .tbl_low_data(tbl_low_data)
   );

   // 50 MHz clock
   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;

   // ------------------------------------------------------------
   // Reference model and bus tasks
   // ------------------------------------------------------------
   // Result and flags {result, ov, z, ac, c} from operands and old flags
   function automatic logic [11:0] alu_model(alu_op_t op, logic [7:0] a, logic [7:0] b,
                                             logic [3:0] f);
      logic [7:0] bb, r, s7;
      logic       ci;
      logic [4:0] lo;
      logic [8:0] full;
      logic [3:0] n;
      n = f;
      r = 8'h00;
      case (op)
         OP_ADD, OP_ADC, OP_SUB, OP_SBC:
         begin
            bb = (op == OP_SUB || op == OP_SBC) ? ~b : b;
            ci = (op == OP_ADD) ? 1'b0 : ((op == OP_SUB) ? 1'b1 : f[0]);
            lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
            s7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
            full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
            r = full[7:0];
            n = {s7[7] ^ full[8], r == 8'h00, lo[4], full[8]};
         end
         OP_RLC:
         begin
            r = {a[6:0], f[0]};
            n[0] = a[7];
         end
         OP_RRC:
         begin
            r = {f[0], a[7:1]};
            n[0] = a[0];
         end
         default:
         begin
            case (op)
               OP_AND:  r = a & b;
               OP_OR:   r = a | b;
               OP_XOR:  r = a ^ b;
               OP_INC:  r = a + 8'h01;
               default: r = a - 8'h01;
            endcase
            n[2] = (r == 8'h00);
         end
      endcase
      return {r, n};
   endfunction

   task automatic reg_write(input logic [2:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      reg_addr  <= addr;
      reg_wdata <= data;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
      if (addr == 3'h0)
         exp_ar = data[3:0];
   endtask

   task automatic reg_read(input logic [2:0] addr, input logic [7:0] exp, input string what);
      @(posedge sys_clk);
      reg_addr <= addr;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      `CHECK(what, exp, reg_rdata)
   endtask

   // Pulses {timeout, clear, sleep} for one cycle
   task automatic sys_event(input logic [2:0] sel);
      @(posedge sys_clk);
      {wdt_timeout, wdt_clear_instr, sleep_instr} <= sel;
      @(posedge sys_clk);
      {wdt_timeout, wdt_clear_instr, sleep_instr} <= 3'h0;
      #1;
   endtask

   task automatic alu_run(input alu_op_t op, input logic [7:0] a, input logic [7:0] b);
      logic [11:0] m;
      m = alu_model(op, a, b, exp_ar);
      @(posedge sys_clk);
      alu_valid <= 1'b1;
      alu_op    <= op;
      alu_a     <= a;
      alu_b     <= b;
      @(posedge sys_clk);
      alu_valid <= 1'b0;
      #1;
      exp_ar = m[3:0];
      `CHECK(op.name(), 1'b1, alu_done)
      `CHECK(op.name(), m[11:4], alu_result)
      reg_read(3'h0, {2'b00, exp_sys, exp_ar}, op.name());
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Cuts a hung run short
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      `CHECK("run_length", 1'b0, 1'b1)
      end_of_test;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, alu_valid, alu_a, alu_b} = '0;
      alu_op = OP_ADD;
      {wdt_timeout, wdt_clear_instr, sleep_instr, tbl_read_instr} = 4'h0;
      {prog_word_valid, prog_word} = '0;
      pc_now_low = 8'h5a;
      miscompares = 0;
      compares = 0;
      exp_sys = 2'b00;
      exp_ar = 4'h0;
      sys_rst = 1'b1;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      reg_read(3'h0, 8'h00, "status_after_reset");
      reg_read(3'h7, 8'h00, "unmapped_read");
      // System flags against writes and events
      reg_write(3'h0, 8'hff);
      reg_read(3'h0, 8'h0f, "status_write_ones");
      sys_event(3'b100);
      reg_read(3'h0, 8'h2f, "timeout_sets");
      reg_write(3'h0, 8'h00);
      reg_read(3'h0, 8'h20, "write_keeps_expiry");
      sys_event(3'b001);
      reg_read(3'h0, 8'h10, "sleep_flags");
      sys_event(3'b100);
      reg_read(3'h0, 8'h30, "both_set");
      sys_event(3'b010);
      reg_read(3'h0, 8'h00, "clear_instr");
      // Every operation, with carries, borrows and zero results
      alu_run(OP_ADD, 8'h7f, 8'h01);
      alu_run(OP_ADD, 8'hff, 8'h01);
      alu_run(OP_ADC, 8'h10, 8'h20);
      alu_run(OP_SUB, 8'h05, 8'h05);
      alu_run(OP_SBC, 8'h00, 8'h01);
      alu_run(OP_SUB, 8'h80, 8'h01);
      alu_run(OP_AND, 8'hf0, 8'h0f);
      alu_run(OP_OR,  8'h40, 8'h02);
      alu_run(OP_XOR, 8'haa, 8'haa);
      alu_run(OP_RLC, 8'h80, 8'h80);
      alu_run(OP_RRC, 8'h02, 8'h02);
      alu_run(OP_INC, 8'hff, 8'hff);
      alu_run(OP_DEC, 8'h01, 8'h01);
      // Program counter low byte jump
      reg_read(3'h1, 8'h5a, "pc_low_read");
      reg_write(3'h1, 8'hc3);
      `CHECK("pc_load", 1'b1, pc_load)
      `CHECK("pc_target", 8'hc3, pc_target_low)
      `CHECK("pc_bubble", 1'b1, pc_bubble)
      @(posedge sys_clk);
      #1;
      `CHECK("pc_bubble_end", 1'b0, pc_bubble)
      `CHECK("pc_load_end", 1'b0, pc_load)
      // Table read through the pointers
      reg_write(3'h2, 8'h33);
      reg_write(3'h3, 8'h12);
      reg_read(3'h2, 8'h33, "ptr_low");
      reg_write(3'h2, 8'h34);
      reg_read(3'h3, 8'h12, "ptr_high");
      @(posedge sys_clk);
      tbl_read_instr <= 1'b1;
      @(posedge sys_clk);
      tbl_read_instr <= 1'b0;
      #1;
      `CHECK("tbl_fetch", 1'b1, tbl_fetch)
      `CHECK("tbl_addr", 16'h1234, tbl_fetch_addr)
      @(posedge sys_clk);
      prog_word       <= 16'ha55c;
      prog_word_valid <= 1'b1;
      @(posedge sys_clk);
      prog_word_valid <= 1'b0;
      #1;
      `CHECK("tbl_low_valid", 1'b1, tbl_low_valid)
      `CHECK("tbl_low_data", 8'h5c, tbl_low_data)
      reg_read(3'h4, 8'ha5, "tbl_high");
      reg_write(3'h4, 8'h00);
      reg_read(3'h4, 8'ha5, "tbl_high_readonly");
      // Reset in mid-run clears the system flags again
      sys_event(3'b100);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      reg_read(3'h0, 8'h00, "status_second_reset");
      end_of_test;
   end

endmodule
